// file: design/pagb_pkg.sv
// Package of constants and carrier types for the port A general purpose I/O block
package pagb_pkg;

	// Port geometry
	localparam int PAGB_PINS = 8;
	localparam int PAGB_ANALOG_CH = 5;

	// Register byte offsets on the Wishbone bus
	localparam logic [7:0] PAGB_ADR_PINS = 8'h00;
	localparam logic [7:0] PAGB_ADR_LATCH = 8'h04;
	localparam logic [7:0] PAGB_ADR_DIR = 8'h08;
	localparam logic [7:0] PAGB_ADR_CONV = 8'h0c;
	localparam logic [7:0] PAGB_ADR_CMP = 8'h10;
	localparam logic [7:0] PAGB_ADR_VREF = 8'h14;
	localparam logic [7:0] PAGB_ADR_OSC = 8'h18;

	// Field positions
	localparam int PAGB_PCFG_LSB = 0;
	localparam int PAGB_VCFG_LSB = 4;
	localparam int PAGB_CMODE_LSB = 0;
	localparam int PAGB_COMPARATOR_ONE_OUTPUT_BIT = 6;
	localparam int PAGB_COMPARATOR_TWO_OUTPUT_BIT = 7;
	localparam int PAGB_REFERENCE_OUTPUT_ENABLE_BIT = 6;
	localparam int PAGB_OSC_LSB = 0;

	// Reset values
	localparam logic [7:0] PAGB_LATCH_RST = 8'h00;
	localparam logic [7:0] PAGB_DIR_RST = 8'hff;
	localparam logic [3:0] PAGB_PCFG_RST = 4'h0;
	localparam logic [1:0] PAGB_VCFG_RST = 2'h0;
	localparam logic [2:0] PAGB_CMODE_RST = 3'h0;
	localparam logic PAGB_REFERENCE_OUTPUT_ENABLE_RST = 1'b0;
	localparam logic [3:0] PAGB_OSC_RST = 4'h8;

	// Comparator modes that matter to the port
	localparam logic [2:0] PAGB_CMODE_OUT_BOTH = 3'h3;
	localparam logic [2:0] PAGB_CMODE_OUT_TWO = 3'h5;
	localparam logic [2:0] PAGB_CMODE_OFF = 3'h7;

	// Highest analog config code for which channel 0 stays analog
	localparam logic [3:0] PAGB_PCFG_AN0_LAST = 4'he;

	// Oscillator configuration codes
	localparam logic [3:0] PAGB_OSC_LP = 4'h0;
	localparam logic [3:0] PAGB_OSC_XT = 4'h1;
	localparam logic [3:0] PAGB_OSC_HS = 4'h2;
	localparam logic [3:0] PAGB_OSC_RC = 4'h3;
	localparam logic [3:0] PAGB_OSC_EC = 4'h4;
	localparam logic [3:0] PAGB_OSC_EXTERNAL_CLOCK_WITH_IO_MODE = 4'h5;
	localparam logic [3:0] PAGB_OSC_HSPLL = 4'h6;
	localparam logic [3:0] PAGB_OSC_RC_OSC_WITH_IO_MODE = 4'h7;
	localparam logic [3:0] PAGB_OSC_INTERNAL_OSC_WITH_IO_MODE = 4'h8;
	localparam logic [3:0] PAGB_OSC_INTERNAL_OSC_CLOCK_OUT_MODE = 4'h9;

	// Instruction cycle clock is the oscillator divided by this
	localparam int PAGB_CYCLE_DIV = 4;

	// Pad drive bundle: level and active low output enable per pin
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe_n;
	} pagb_pad_type;

	// Software control bundle
	typedef struct packed {
		logic [3:0] pcfg;
		logic [1:0] vcfg;
		logic [2:0] cmode;
		logic reference_output_enable;
		logic [3:0] osc;
	} pagb_ctrl_type;

endpackage // pagb_pkg

// file: design/pagb_port_a.sv
// Port A general purpose I/O block with Wishbone register access and pin sharing
//
// Function
// - Eight pins, each one individually an input or an output.
// - Direction bit one puts the pin driver in high impedance.
// - Direction bit zero drives the pin with its output latch bit.
// - Port register reads pin levels; writing it writes the output latch.
// - Latch register is separately addressed and reads back the latched value.
// - Pins 6 and 7 used by the oscillator read zero in all registers.
// - Pin 6 digital I/O only in RC, internal and external clock I/O modes.
// - Pin 7 digital I/O off in every external oscillator mode.
// - Pin 6 drives cycle clock at oscillator over four in clock out modes.
// - After reset pins 0-3 and 5 are analog reading zero; pin 4 digital input.
// - Analog config field picks analog pins; analog pins lose digital input.
// - Analog pins still drive their latch value when direction bit is zero.
// - Routed comparator outputs override latch data on pins 4 and 5.
// - Reference output enabled disables pin 2 digital I/O regardless of direction.
// - Pin 4 level also feeds the timer zero clock input.
// - Pin 5 as input supplies the serial module slave select.
// - Oscillator, clock and reference functions ignore the direction bit.
module pagb_port_a (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pads
	input wire logic [7:0] pad_in_i,
	output pagb_pkg::pagb_pad_type pads_o,
	// Comparator outputs from the comparator block
	input wire logic comparator_one_output_i,
	input wire logic comparator_two_output_i,
	// Peripheral feeds
	output logic timer_zero_clock_input_o,
	output logic sync_serial_select_n_o,
	output logic [4:0] analog_pin_select_o,
	output logic reference_output_enable_o
);

	// Register state
	logic [7:0] port_a_output_latch;
	logic [7:0] port_a_direction;
	pagb_pkg::pagb_ctrl_type ctrl;

	// Derived pin control
	logic [7:0] pin_sync;
	logic [7:0] in_enable;
	logic [7:0] drive_enable;
	logic [7:0] drive_value;
	logic [7:0] port_mask;
	logic [7:0] pins_view;
	logic [4:0] analog_sel;
	logic comparators_off;
	logic cmp_one_routed;
	logic cmp_two_routed;
	logic pin6_io;
	logic pin7_io;
	logic pin6_clock_out;
	logic cycle_clock;
	logic [1:0] div_count;
	logic [31:0] next_dat;
	logic bus_req;
	logic wr_lane;

	// Channel n stays analog while the config code is at or below its own limit
	function automatic logic [4:0] analog_select(input logic [3:0] pcfg);
		logic [4:0] sel;
		sel = '0;
		for (int n = 0; n < pagb_pkg::PAGB_ANALOG_CH; n++)
		begin
			sel[n] = (pcfg <= (pagb_pkg::PAGB_PCFG_AN0_LAST - 4'(n)));
		end
		return sel;
	endfunction

	// Pin 6 usable as port pin
	function automatic logic osc_pin6_io(input logic [3:0] osc);
		logic io;
		io = 1'b0;
		case (osc)
			pagb_pkg::PAGB_OSC_RC_OSC_WITH_IO_MODE: io = 1'b1;
			pagb_pkg::PAGB_OSC_INTERNAL_OSC_WITH_IO_MODE: io = 1'b1;
			pagb_pkg::PAGB_OSC_EXTERNAL_CLOCK_WITH_IO_MODE: io = 1'b1;
			default: io = 1'b0;
		endcase
		return io;
	endfunction

	// Pin 7 usable as port pin: only the internal oscillator modes free it
	function automatic logic osc_pin7_io(input logic [3:0] osc);
		logic io;
		io = 1'b0;
		case (osc)
			pagb_pkg::PAGB_OSC_INTERNAL_OSC_WITH_IO_MODE: io = 1'b1;
			pagb_pkg::PAGB_OSC_INTERNAL_OSC_CLOCK_OUT_MODE: io = 1'b1;
			default: io = 1'b0;
		endcase
		return io;
	endfunction

	// Pin 6 carries the cycle clock
	function automatic logic osc_clock_out(input logic [3:0] osc);
		logic co;
		co = 1'b0;
		case (osc)
			pagb_pkg::PAGB_OSC_RC: co = 1'b1;
			pagb_pkg::PAGB_OSC_INTERNAL_OSC_CLOCK_OUT_MODE: co = 1'b1;
			pagb_pkg::PAGB_OSC_EC: co = 1'b1;
			default: co = 1'b0;
		endcase
		return co;
	endfunction

	// Pad levels are asynchronous to the bus clock
	pagb_sync #(
		.WIDTH(pagb_pkg::PAGB_PINS)
	) u_pin_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.d_i(pad_in_i),
		.q_o(pin_sync)
	);

	// Decode of the sharing controls
	assign analog_sel = analog_select(ctrl.pcfg);
	assign comparators_off = (ctrl.cmode == pagb_pkg::PAGB_CMODE_OFF);
	assign cmp_one_routed = (ctrl.cmode == pagb_pkg::PAGB_CMODE_OUT_BOTH);
	assign cmp_two_routed = (ctrl.cmode == pagb_pkg::PAGB_CMODE_OUT_BOTH)
		|| (ctrl.cmode == pagb_pkg::PAGB_CMODE_OUT_TWO);
	assign pin6_io = osc_pin6_io(ctrl.osc);
	assign pin7_io = osc_pin7_io(ctrl.osc);
	assign pin6_clock_out = osc_clock_out(ctrl.osc);

	// Bits that belong to the port; oscillator pins drop out of every register
	assign port_mask = {pin7_io, pin6_io, 6'h3f};

	// Digital input paths; comparator inputs share pins 0-3 so those need them off
	always_comb
	begin
		in_enable[0] = !analog_sel[0] && comparators_off;
		in_enable[1] = !analog_sel[1] && comparators_off;
		in_enable[2] = !analog_sel[2] && comparators_off && !ctrl.reference_output_enable;
		in_enable[3] = !analog_sel[3] && comparators_off;
		in_enable[4] = 1'b1;
		in_enable[5] = !analog_sel[4];
		in_enable[6] = pin6_io;
		in_enable[7] = pin7_io;
	end

	// Driver enables follow the direction bit, analog selection does not matter
	always_comb
	begin
		drive_enable = ~port_a_direction & port_mask;
		if (ctrl.reference_output_enable)
		begin
			drive_enable[2] = 1'b0;
		end
		if (pin6_clock_out)
		begin
			drive_enable[6] = 1'b1;
		end
	end

	// Driven values: latch, unless a comparator or the cycle clock takes over
	always_comb
	begin
		drive_value = port_a_output_latch;
		if (cmp_one_routed)
		begin
			drive_value[4] = comparator_one_output_i;
		end
		if (cmp_two_routed)
		begin
			drive_value[5] = comparator_two_output_i;
		end
		if (pin6_clock_out)
		begin
			drive_value[6] = cycle_clock;
		end
	end

	// Free running divider for the instruction cycle clock
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div_count <= 2'h0;
		end
		else
		begin
			// Wrap in integer arithmetic: the divisor itself does not fit the counter's width
			div_count <= 2'((int'(div_count) + 1) % pagb_pkg::PAGB_CYCLE_DIV);
		end
	end

	assign cycle_clock = div_count[1];

	// Pads driven from flip-flops; a one cycle lag keeps glitches off the pins
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pads_o.level <= 8'h00;
			pads_o.oe_n <= 8'hff;
		end
		else
		begin
			pads_o.level <= drive_value;
			pads_o.oe_n <= ~drive_enable;
		end
	end

	// Peripheral feeds: timer and select from the synchronised pins, analog select and reference from the controls
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			timer_zero_clock_input_o <= 1'b0;
			sync_serial_select_n_o <= 1'b1;
			analog_pin_select_o <= 5'h1f;
			reference_output_enable_o <= 1'b0;
		end
		else
		begin
			timer_zero_clock_input_o <= pin_sync[4];
			// Deselected unless pin 5 is an input, so an output never selects
			sync_serial_select_n_o <= port_a_direction[5] ? pin_sync[5] : 1'b1;
			analog_pin_select_o <= analog_sel;
			reference_output_enable_o <= ctrl.reference_output_enable;
		end
	end

	// Pin view seen by software
	assign pins_view = pin_sync & in_enable & port_mask;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_lane = bus_req && wb_we_i && wb_sel_i[0];

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		next_dat = 32'h0000_0000;
		case (wb_adr_i)
			pagb_pkg::PAGB_ADR_PINS: next_dat[7:0] = pins_view;
			pagb_pkg::PAGB_ADR_LATCH: next_dat[7:0] = port_a_output_latch & port_mask;
			pagb_pkg::PAGB_ADR_DIR: next_dat[7:0] = port_a_direction & port_mask;
			pagb_pkg::PAGB_ADR_CONV:
			begin
				next_dat[pagb_pkg::PAGB_PCFG_LSB +: 4] = ctrl.pcfg;
				next_dat[pagb_pkg::PAGB_VCFG_LSB +: 2] = ctrl.vcfg;
			end
			pagb_pkg::PAGB_ADR_CMP:
			begin
				next_dat[pagb_pkg::PAGB_CMODE_LSB +: 3] = ctrl.cmode;
				next_dat[pagb_pkg::PAGB_COMPARATOR_ONE_OUTPUT_BIT] = comparator_one_output_i;
				next_dat[pagb_pkg::PAGB_COMPARATOR_TWO_OUTPUT_BIT] = comparator_two_output_i;
			end
			pagb_pkg::PAGB_ADR_VREF: next_dat[pagb_pkg::PAGB_REFERENCE_OUTPUT_ENABLE_BIT] = ctrl.reference_output_enable;
			pagb_pkg::PAGB_ADR_OSC: next_dat[pagb_pkg::PAGB_OSC_LSB +: 4] = ctrl.osc;
			default: next_dat = 32'h0000_0000;
		endcase
	end

	// Bus answer: one cycle after the strobe, every address is acknowledged
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i)
			begin
				wb_dat_o <= next_dat;
			end
		end
	end

	// Output latch: both the port and the latch offset write it
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			port_a_output_latch <= pagb_pkg::PAGB_LATCH_RST;
		end
		else if (wr_lane && (wb_adr_i == pagb_pkg::PAGB_ADR_PINS
			|| wb_adr_i == pagb_pkg::PAGB_ADR_LATCH))
		begin
			port_a_output_latch <= wb_dat_i[7:0];
		end
	end

	// Direction register, all inputs after reset
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			port_a_direction <= pagb_pkg::PAGB_DIR_RST;
		end
		else if (wr_lane && wb_adr_i == pagb_pkg::PAGB_ADR_DIR)
		begin
			port_a_direction <= wb_dat_i[7:0];
		end
	end

	// Sharing controls; analog config resets to all analog
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl.pcfg <= pagb_pkg::PAGB_PCFG_RST;
			ctrl.vcfg <= pagb_pkg::PAGB_VCFG_RST;
			ctrl.cmode <= pagb_pkg::PAGB_CMODE_RST;
			ctrl.reference_output_enable <= pagb_pkg::PAGB_REFERENCE_OUTPUT_ENABLE_RST;
			ctrl.osc <= pagb_pkg::PAGB_OSC_RST;
		end
		else if (wr_lane)
		begin
			case (wb_adr_i)
				pagb_pkg::PAGB_ADR_CONV:
				begin
					ctrl.pcfg <= wb_dat_i[pagb_pkg::PAGB_PCFG_LSB +: 4];
					ctrl.vcfg <= wb_dat_i[pagb_pkg::PAGB_VCFG_LSB +: 2];
				end
				pagb_pkg::PAGB_ADR_CMP: ctrl.cmode <= wb_dat_i[pagb_pkg::PAGB_CMODE_LSB +: 3];
				pagb_pkg::PAGB_ADR_VREF: ctrl.reference_output_enable <= wb_dat_i[pagb_pkg::PAGB_REFERENCE_OUTPUT_ENABLE_BIT];
				pagb_pkg::PAGB_ADR_OSC: ctrl.osc <= wb_dat_i[pagb_pkg::PAGB_OSC_LSB +: 4];
				default: ctrl.osc <= ctrl.osc;
			endcase
		end
	end

endmodule // pagb_port_a

// file: design/pagb_sync.sv
// Two flip-flop level synchroniser for pad inputs
module pagb_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Data
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta;

	// First stage feeds only the second stage to keep metastability contained
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta <= '0;
			q_o <= '0;
		end
		else
		begin
			meta <= d_i;
			q_o <= meta;
		end
	end

endmodule // pagb_sync

// file: verif/pagb_pad_model.sv
// Pad model: resolves each pin from the block and from the outside world
module pagb_pad_model (
	// Clock
	input wire logic clock_i,
	// Block side and outside drive
	input wire pagb_pkg::pagb_pad_type pads_i,
	input wire logic [7:0] lvl_i,
	input wire logic [7:0] drv_i,
	// Resolved pin levels
	output logic [7:0] pad_o
);
	logic [7:0] wander = 8'h00;
	// A floating pin has no steady level, so it keeps flipping
	always @(posedge clock_i)
		wander <= ~wander;
	// The block wins where its enable is low; otherwise the outside or nothing
	assign pad_o = (~pads_i.oe_n & pads_i.level)
		| (pads_i.oe_n & ((drv_i & lvl_i) | (~drv_i & wander)));
endmodule // pagb_pad_model

// file: verif/pagb_port_a_chk.sv
// Assertion checker for the port A block, bound to its ports
module pagb_port_a_chk (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pads and feeds
	input wire logic [7:0] pad_in_i,
	input wire pagb_pkg::pagb_pad_type pads_o,
	input wire logic comparator_one_output_i,
	input wire logic comparator_two_output_i,
	input wire logic timer_zero_clock_input_o,
	input wire logic sync_serial_select_n_o,
	input wire logic [4:0] analog_pin_select_o,
	input wire logic reference_output_enable_o
);
	logic [7:0] dir, lat;
	logic [3:0] osc;
	logic [2:0] cm;
	logic rf, wr, p6, p7, ck;
	// A write lands on the edge that takes a new request
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~wb_ack_o;
	assign ck = osc inside {4'h3, 4'h4, 4'h9};
	assign p6 = osc inside {4'h5, 4'h7, 4'h8};
	assign p7 = osc inside {4'h8, 4'h9};
	// Shadow of the controls, so pad behaviour can be judged from the bus alone
	always_ff @(posedge clock_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			dir <= pagb_pkg::PAGB_DIR_RST;
			lat <= pagb_pkg::PAGB_LATCH_RST;
			osc <= pagb_pkg::PAGB_OSC_RST;
			cm <= pagb_pkg::PAGB_CMODE_RST;
			rf <= pagb_pkg::PAGB_REFERENCE_OUTPUT_ENABLE_RST;
		end
		else if (wr)
			case (wb_adr_i)
				8'h00, 8'h04: lat <= wb_dat_i[7:0];
				8'h08: dir <= wb_dat_i[7:0];
				8'h10: cm <= wb_dat_i[2:0];
				8'h14: rf <= wb_dat_i[6];
				8'h18: osc <= wb_dat_i[3:0];
				default: ;
			endcase
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	hiz_dir_a:
		assert property ({pads_o.oe_n[5:3], pads_o.oe_n[1:0]} == $past({dir[5:3], dir[1:0]}))
		else $error("pad enable differs from direction");
	drive_lat_a:
		assert property ((~$past(dir[1:0]) & (pads_o.level[1:0] ^ $past(lat[1:0]))) == 2'h0)
		else $error("driven pad differs from latch");
	ref_pin_a:
		assert property ($past(rf) |-> pads_o.oe_n[2] && reference_output_enable_o)
		else $error("pin two driven with reference out");
	cmp_one_a:
		assert property ($past(cm == 3'h3 && !dir[4]) |-> pads_o.level[4] == $past(comparator_one_output_i))
		else $error("pin four lacks comparator one");
	cmp_two_a:
		assert property ($past((cm == 3'h3 || cm == 3'h5) && !dir[5])
			|-> pads_o.level[5] == $past(comparator_two_output_i))
		else $error("pin five lacks comparator two");
	clk_out_a:
		assert property ($past(ck) && $past(ck, 4)
			|-> !pads_o.oe_n[6] && pads_o.level[6] != $past(pads_o.level[6], 2))
		else $error("pin six cycle clock wrong");
	pin_six_a:
		assert property (!$past(p6 || ck) |-> pads_o.oe_n[6])
		else $error("pin six driven in oscillator mode");
	pin_seven_a:
		assert property (!$past(p7) |-> pads_o.oe_n[7])
		else $error("pin seven driven in oscillator mode");
	tmr_feed_a:
		assert property ($past(rst_n_i, 3) |-> timer_zero_clock_input_o == $past(pad_in_i[4], 3))
		else $error("timer input does not follow pin four");
	sel_feed_a:
		assert property (!$past(dir[5]) |-> sync_serial_select_n_o)
		else $error("select active while pin five is output");
	// Main scenarios reached
	cover property ($past(ck) && $past(ck, 4));
	cover property ($past(cm == 3'h3 && !dir[4]));
	cover property ($past(rf));
endmodule // pagb_port_a_chk

bind pagb_port_a pagb_port_a_chk chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pad_in_i(pad_in_i), .pads_o(pads_o), .comparator_one_output_i(comparator_one_output_i),
	.comparator_two_output_i(comparator_two_output_i),
	.timer_zero_clock_input_o(timer_zero_clock_input_o),
	.sync_serial_select_n_o(sync_serial_select_n_o),
	.analog_pin_select_o(analog_pin_select_o),
	.reference_output_enable_o(reference_output_enable_o));

// file: verif/tb_pagb_port_a.sv
// Self-checking bench for the port A block
module tb_pagb_port_a;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] AP = pagb_pkg::PAGB_ADR_PINS;
	localparam logic [7:0] AL = pagb_pkg::PAGB_ADR_LATCH;
	localparam logic [7:0] AD = pagb_pkg::PAGB_ADR_DIR;
	localparam logic [7:0] AC = pagb_pkg::PAGB_ADR_CONV;
	localparam logic [7:0] AM = pagb_pkg::PAGB_ADR_CMP;
	localparam logic [7:0] AV = pagb_pkg::PAGB_ADR_VREF;
	localparam logic [7:0] AO = pagb_pkg::PAGB_ADR_OSC;
	logic clock, rst_n, cyc, stb, we, ack, c1, c2, tmr, ssn, rfo;
	logic [7:0] adr, pad, lvl;
	logic [3:0] sel;
	logic [31:0] wd, rd, q;
	logic [4:0] ans;
	pagb_pkg::pagb_pad_type pads;
	int errors, checks_done;
	pagb_port_a dut (.clock_i(clock), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .pad_in_i(pad), .pads_o(pads), .comparator_one_output_i(c1),
		.comparator_two_output_i(c2), .timer_zero_clock_input_o(tmr),
		.sync_serial_select_n_o(ssn), .analog_pin_select_o(ans),
		.reference_output_enable_o(rfo));
	pagb_pad_model pm (.clock_i(clock), .pads_i(pads), .lvl_i(lvl), .drv_i(8'hff), .pad_o(pad));
	// Clock at 200 MHz
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One classic cycle; waits for ack but never assumes its delay
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wd <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rd;
		// A missing answer counts against the run instead of hanging it
		if (ack !== 1'b1)
		begin
			errors++;
			$display("BAD %0t no acknowledge", $time);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
		bus(1'b1, a, {24'h0, d}, s);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(q, e);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic t_reset;
		rc(AD, 32'hff);
		rc(AL, 32'h0);
		rc(AP, 32'hd0);
		chk({27'h0, ans}, 32'h1f);
		chk({16'h0, pads}, 32'h00ff);
	endtask
	task automatic t_digital;
		wr(AC, 8'h0f);
		wr(AM, 8'h07);
		lvl <= 8'h3c;
		idle(4);
		rc(AP, 32'h3c);
		chk({27'h0, ans}, 32'h0);
		rc(AC, 32'h0f);
		wr(AP, 8'ha5);
		rc(AL, 32'ha5);
		rc(AP, 32'h3c);
		wr(AD, 8'h00);
		idle(4);
		rc(AP, 32'ha5);
		wr(AC, 8'h00);
		idle(4);
		rc(AP, 32'h80);
		chk({16'h0, pads}, 32'ha500);
		wr(AD, 8'hff);
		wr(AC, 8'h0f);
	endtask
	task automatic t_osc;
		logic p6, p7, b;
		wr(AD, 8'hff);
		for (int i = 0; i < 16; i++)
		begin
			p6 = i inside {5, 7, 8};
			p7 = i inside {8, 9};
			wr(AO, i[7:0]);
			rc(AD, {24'h0, p7, p6, 6'h3f});
			rc(AL, {24'h0, p7, 7'h25});
		end
		wr(AO, 8'h03);
		idle(4);
		b = pads.level[6];
		idle(2);
		chk({31'h0, pads.level[6] ^ b}, 32'h1);
		chk({31'h0, pads.oe_n[6]}, 32'h0);
		wr(AO, 8'h08);
	endtask
	task automatic t_cmp;
		wr(AL, 8'h00);
		wr(AD, 8'h00);
		wr(AM, 8'h03);
		c1 <= 1'b1;
		c2 <= 1'b1;
		idle(3);
		chk({30'h0, pads.level[5:4]}, 32'h3);
		wr(AM, 8'h05);
		idle(3);
		chk({30'h0, pads.level[5:4]}, 32'h2);
		wr(AM, 8'h07);
		idle(3);
		chk({30'h0, pads.level[5:4]}, 32'h0);
	endtask
	task automatic t_ref;
		wr(AL, 8'hff);
		wr(AV, 8'h40);
		idle(4);
		chk({31'h0, pads.oe_n[2]}, 32'h1);
		chk({31'h0, rfo}, 32'h1);
		rc(AP, 32'hfb);
		wr(AV, 8'h00);
	endtask
	task automatic t_feed;
		wr(AL, 8'h00);
		wr(AD, 8'hff);
		lvl <= 8'h00;
		idle(5);
		chk({30'h0, tmr, ssn}, 32'h0);
		lvl <= 8'h30;
		idle(5);
		chk({30'h0, tmr, ssn}, 32'h3);
		wr(AD, 8'hdf);
		lvl <= 8'h00;
		idle(5);
		chk({30'h0, tmr, ssn}, 32'h1);
	endtask
	task automatic t_bus;
		wr(8'h1c, 8'hff);
		rc(8'h1c, 32'h0);
		wr(AL, 8'h55, 4'he);
		rc(AL, 32'h0);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		{cyc, stb, we, c1, c2} = 5'h0;
		adr = 8'h00;
		sel = 4'hf;
		wd = 32'h0;
		lvl = 8'hff;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_reset;
		t_digital;
		t_osc;
		t_cmp;
		t_ref;
		t_feed;
		t_bus;
		end_of_test;
	end
	// Watchdog, well past the few hundred cycles the tests need
	initial
	begin
		#20000;
		errors++;
		end_of_test;
	end
endmodule // tb_pagb_port_a
